/* File: sbcw_map.svh */
// sbcw_map.svh: offsets, fields, codes and timing of the watchdog block.
// assumes: included by bare name from the design.
`ifndef SBCW_MAP_SVH
`define SBCW_MAP_SVH
// register byte offsets
`define SBCW_A_WDCTL    8'h00
`define SBCW_A_WDSTAT   8'h05
`define SBCW_A_CFG      8'h74
// configuration register
`define SBCW_CFG_PRESET 8'h08
`define SBCW_CFG_WMASK  8'h3D
`define SBCW_UV_HI      5
`define SBCW_UV_LO      4
`define SBCW_FN_BIT     3
`define SBCW_SD_BIT     2
`define SBCW_SLP_BIT    0
// watchdog control fields and codes
`define SBCW_WMC_HI     7
`define SBCW_WMC_LO     5
`define SBCW_NWP_HI     3
`define SBCW_NWP_LO     0
`define SBCW_WMC_AUTO   3'h1
`define SBCW_WMC_TMO    3'h2
`define SBCW_WMC_WIN    3'h4
`define SBCW_NWP_DEF    4'h4
// period codes and their times in ms
`define SBCW_P8_CODE    4'h8
`define SBCW_P8_MS      8
`define SBCW_P16_CODE   4'h1
`define SBCW_P16_MS     16
`define SBCW_P32_CODE   4'h2
`define SBCW_P32_MS     32
`define SBCW_P64_CODE   4'hB
`define SBCW_P64_MS     64
`define SBCW_P128_CODE  4'h4
`define SBCW_P128_MS    128
`define SBCW_P256_CODE  4'hD
`define SBCW_P256_MS    256
`define SBCW_P1024_CODE 4'hE
`define SBCW_P1024_MS   1024
`define SBCW_P4096_CODE 4'h7
`define SBCW_P4096_MS   4096
// reset source codes
`define SBCW_RSC_POR    5'h00
`define SBCW_RSC_EARLY  5'h0E
`define SBCW_RSC_OVF    5'h0F
`define SBCW_RSC_ILLWM  5'h10
`define SBCW_RSC_EXT    5'h11
// watchdog phase codes
`define SBCW_PH_OFF     2'h0
`define SBCW_PH_FIRST   2'h1
`define SBCW_PH_SECOND  2'h2
// timing: clock rate, reset pulse, pin blanking after release
`define SBCW_CLK_KHZ    25000
`define SBCW_RST_MS     1
`define SBCW_BLANK      2'h3
`endif

/* File: sbcw_pkg.sv */
// sbcw_pkg.sv: types shared by the watchdog block.
// assumes: sbcw_map.svh holds the numeric constants.
package sbcw_pkg;
    // chip operating mode, one-hot
    typedef enum logic [3:0] {
        sbcw_op_normal  = 4'h1,
        sbcw_op_standby = 4'h2,
        sbcw_op_sleep   = 4'h4,
        sbcw_op_other   = 4'h8
    } sbcw_opmode_e;
    // effective watchdog mode, one-hot
    typedef enum logic [2:0] {
        sbcw_wd_off = 3'h1,
        sbcw_wd_tmo = 3'h2,
        sbcw_wd_win = 3'h4
    } sbcw_wdm_e;
    // one register access from the link side
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sbcw_lnk_req_s;
endpackage

/* File: sbcw_watchdog.sv */
// sbcw_watchdog.sv: watchdog supervisor with override config and reset pin.
// assumes: register accesses arrive on lnk_clk, one at a time; op_mode,
// rxd_low and event pulses come from chip logic on clk.
//
// Overview of operation
// - forced-normal override keeps watchdog fully off
// - config bits 5:4 load startup threshold
// - config bit 3 enables forced-normal, preset set
// - config bit 2 enables sw-dev, preset clear
// - config bit 0 set ignores sleep commands
// - config register persists through system resets; power-up reset loads the preset
// - status bits 3,2 show both overrides
// - status bits 1:0 report off/first/second half
// - sw-dev reset loads autonomous mode code
// - window mode: code 100 in normal
// - early trigger or overflow resets, source recorded
// - second-half trigger restarts timer
// - timeout mode for 010, or 100 in standby or sleep; off in other mode
// - timeout trigger restarts, overflow sets fail flag
// - overflow with fail flag set resets outside sleep
// - sleep timeout overflow raises wake-up event
// - sleep wake with flag: rxd low, regulator on
// - autonomous: timeout in normal or standby rxd low, off with sw-dev set
// - autonomous wake: rxd low, restart, sleep->standby
// - system reset drives reset pin low pulse
// - external low on reset pin is reset source
// - valid control write triggers, new values immediate
// - mode change in normal forces reset 10000
// - eight periods 8..4096 ms, default 128
// - invalid codes abandoned, interface failure raised
`timescale 1ns/1ps
`include "sbcw_map.svh"
module sbcw_watchdog
    import sbcw_pkg::*;
#(
    parameter int unsigned CYC_PER_MS    = `SBCW_CLK_KHZ,
    parameter int unsigned RST_PULSE_CYC = `SBCW_RST_MS * `SBCW_CLK_KHZ
) (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          lnk_clk,
    input  wire logic          lnk_reset,
    input  wire logic          lnk_req,
    input  wire sbcw_lnk_req_s lnk_cmd,
    output logic               lnk_busy,
    output logic [7:0]         lnk_rdata,
    output logic               lnk_done,
    input  wire sbcw_opmode_e  op_mode,
    input  wire logic          rxd_low,
    input  wire logic          wake_captured,
    input  wire logic          sleep_cmd,
    input  wire logic          wdg_fail_clr,
    output logic               sleep_go,
    output logic               wake_event,
    output logic               stby_go,
    output logic               spi_fail,
    output logic               sys_reset,
    output logic [4:0]         reset_source_code,
    output logic               wdg_fail_flag,
    output logic               force_rxd_low,
    output logic               regulator_on,
    output logic [1:0]         uv_threshold_sel,
    input  wire logic          reset_pin_n_i,
    output logic               reset_pin_n_o,
    output logic               reset_pin_n_oe_n
);
    // ==========================================================
    // declarations
    logic          req_tgl_ff;   // link: request toggle
    sbcw_lnk_req_s hold_ff;      // link: access held until answered
    logic          ack_s1_ff;    // link: ack synchroniser
    logic          ack_s2_ff;
    logic          ack_s3_ff;
    logic [7:0]    lnk_rdata_ff;
    logic          lnk_done_ff;
    logic          req_s1_ff;    // core: request synchroniser
    logic          req_s2_ff;
    logic          req_s3_ff;
    logic          ack_tgl_ff;   // core: answer toggle
    logic [7:0]    rdat_ff;      // core: answer data
    logic [7:0]    cfg_ff;       // non-volatile configuration
    logic [2:0]    wmc_ff;       // wdg_mode_sel
    logic [3:0]    nwp_ff;       // wdg_period_sel
    sbcw_wdm_e     wdm_ff;       // effective mode last cycle
    sbcw_wdm_e     nxt_wdm;
    logic [31:0]   cnt_ff;       // watchdog timer
    logic          wdf_ff;       // wdg_fail_flag
    logic          frx_ff;       // force_rxd_low
    logic          reg_on_ff;    // regulator_out enable
    logic          drive_ff;     // reset pin driven low
    logic [31:0]   pcnt_ff;      // reset pulse length
    logic [1:0]    blank_ff;     // ignore pin while it recovers
    logic          pin_s1_ff;    // reset pin synchroniser
    logic          pin_s2_ff;
    logic [4:0]    rsc_ff;       // reset_source_code
    logic          sys_rst_ff;
    logic          started_ff;
    logic [1:0]    uv_ff;
    logic          sleep_go_ff;
    logic          wake_ev_ff;
    logic          stby_go_ff;
    logic          spi_fail_ff;
    logic          req_evt;      // one access arrived on clk
    logic          wr_ctl;       // write to control register
    logic          trig;         // valid trigger write
    logic          wc_bad;       // mode change attempted in normal
    logic          fn;
    logic          sd;
    logic [31:0]   period;
    logic [31:0]   half;
    logic          ovf;
    logic          early;
    logic          slp_ovf;
    logic          sreq;
    logic [4:0]    nxt_rsc;
    logic [1:0]    phase;
    logic [2:0]    new_wmc;
    logic [3:0]    new_nwp;

    // ==========================================================
    // helpers
    // period time in ms for a code, zero for an invalid code
    function automatic int unsigned per_ms(input logic [3:0] c);
        case (c)
            `SBCW_P8_CODE:    per_ms = `SBCW_P8_MS;
            `SBCW_P16_CODE:   per_ms = `SBCW_P16_MS;
            `SBCW_P32_CODE:   per_ms = `SBCW_P32_MS;
            `SBCW_P64_CODE:   per_ms = `SBCW_P64_MS;
            `SBCW_P128_CODE:  per_ms = `SBCW_P128_MS;
            `SBCW_P256_CODE:  per_ms = `SBCW_P256_MS;
            `SBCW_P1024_CODE: per_ms = `SBCW_P1024_MS;
            `SBCW_P4096_CODE: per_ms = `SBCW_P4096_MS;
            default:          per_ms = 0;
        endcase
    endfunction

    // ==========================================================
    // link side: hold one access, toggle toward the core
    assign lnk_busy = req_tgl_ff ^ ack_s2_ff;
    always_ff @(posedge lnk_clk) begin
        if (lnk_reset) begin
            req_tgl_ff <= 1'b0;
            hold_ff    <= '0;
        end else if (lnk_req && !lnk_busy) begin
            // held data stays stable until the ack returns
            hold_ff    <= lnk_cmd;
            req_tgl_ff <= ~req_tgl_ff;
        end
    end

    // link side: ack synchroniser and answer capture
    always_ff @(posedge lnk_clk) begin
        if (lnk_reset) begin
            ack_s1_ff    <= 1'b0;
            ack_s2_ff    <= 1'b0;
            ack_s3_ff    <= 1'b0;
            lnk_rdata_ff <= 8'h00;
            lnk_done_ff  <= 1'b0;
        end else begin
            ack_s1_ff   <= ack_tgl_ff;
            ack_s2_ff   <= ack_s1_ff;
            ack_s3_ff   <= ack_s2_ff;
            lnk_done_ff <= ack_s2_ff ^ ack_s3_ff;
            // core data was settled when its toggle moved
            if (ack_s2_ff ^ ack_s3_ff) begin
                lnk_rdata_ff <= rdat_ff;
            end
        end
    end
    assign lnk_rdata = lnk_rdata_ff;
    assign lnk_done  = lnk_done_ff;

    // ==========================================================
    // core: request synchroniser
    always_ff @(posedge clk) begin
        if (reset) begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            req_s3_ff <= 1'b0;
        end else begin
            req_s1_ff <= req_tgl_ff;
            req_s2_ff <= req_s1_ff;
            req_s3_ff <= req_s2_ff;
        end
    end
    assign req_evt = req_s2_ff ^ req_s3_ff;

    // ==========================================================
    // core: decode
    assign fn      = cfg_ff[`SBCW_FN_BIT];
    assign sd      = cfg_ff[`SBCW_SD_BIT];
    assign new_wmc = hold_ff.wdata[`SBCW_WMC_HI:`SBCW_WMC_LO];
    assign new_nwp = hold_ff.wdata[`SBCW_NWP_HI:`SBCW_NWP_LO];
    assign wr_ctl  = req_evt && hold_ff.we && (hold_ff.addr == `SBCW_A_WDCTL);
    assign trig    = wr_ctl && (per_ms(new_nwp) != 0) &&
                     ((new_wmc == `SBCW_WMC_AUTO) || (new_wmc == `SBCW_WMC_TMO) ||
                      (new_wmc == `SBCW_WMC_WIN));
    assign wc_bad  = trig && (new_wmc != wmc_ff) && (op_mode == sbcw_op_normal);

    assign period  = 32'(per_ms(nwp_ff) * CYC_PER_MS);
    assign half    = period >> 1;
    assign ovf     = (wdm_ff != sbcw_wd_off) && (cnt_ff >= period - 32'h1);
    assign early   = trig && (wdm_ff == sbcw_wd_win) && (cnt_ff < half);
    assign slp_ovf = ovf && (wdm_ff == sbcw_wd_tmo) && (op_mode == sbcw_op_sleep);

    // effective watchdog mode
    always_comb begin
        nxt_wdm = sbcw_wd_off;
        // override and reset mode force off
        if (fn || drive_ff) begin
            nxt_wdm = sbcw_wd_off;
        end else begin
            case (wmc_ff)
                `SBCW_WMC_WIN: begin
                    if (op_mode == sbcw_op_normal) begin
                        nxt_wdm = sbcw_wd_win;
                    end else if (op_mode == sbcw_op_standby || op_mode == sbcw_op_sleep) begin
                        nxt_wdm = sbcw_wd_tmo;
                    end
                end
                `SBCW_WMC_TMO: begin
                    if (op_mode != sbcw_op_other) begin
                        nxt_wdm = sbcw_wd_tmo;
                    end
                end
                `SBCW_WMC_AUTO: begin
                    if (!sd && (op_mode == sbcw_op_normal ||
                        (op_mode == sbcw_op_standby && (rxd_low || frx_ff)))) begin
                        nxt_wdm = sbcw_wd_tmo;
                    end
                end
                default: nxt_wdm = sbcw_wd_off;
            endcase
        end
    end

    // system reset request and its source, first cause wins
    always_comb begin
        sreq    = 1'b0;
        nxt_rsc = rsc_ff;
        if (drive_ff) begin
            sreq = 1'b0;
        end else if (wc_bad) begin
            sreq    = 1'b1;
            nxt_rsc = `SBCW_RSC_ILLWM;
        end else if (early) begin
            sreq    = 1'b1;
            nxt_rsc = `SBCW_RSC_EARLY;
        end else if (ovf && (wdm_ff == sbcw_wd_win ||
                     (wdf_ff && op_mode != sbcw_op_sleep))) begin
            sreq    = 1'b1;
            nxt_rsc = `SBCW_RSC_OVF;
        end else if (!pin_s2_ff && blank_ff == 2'h0) begin
            sreq    = 1'b1;
            nxt_rsc = `SBCW_RSC_EXT;
        end
    end

    always_comb begin
        if (wdm_ff == sbcw_wd_off) begin
            phase = `SBCW_PH_OFF;
        end else if (cnt_ff < half) begin
            phase = `SBCW_PH_FIRST;
        end else begin
            phase = `SBCW_PH_SECOND;
        end
    end

    // ==========================================================
    // core: register access answer
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_tgl_ff <= 1'b0;
            rdat_ff    <= 8'h00;
        end else if (req_evt) begin
            ack_tgl_ff <= ~ack_tgl_ff;
            case (hold_ff.addr)
                `SBCW_A_WDCTL:  rdat_ff <= {wmc_ff, 1'b0, nwp_ff};
                `SBCW_A_WDSTAT: rdat_ff <= {4'h0, fn, sd, phase};
                `SBCW_A_CFG:    rdat_ff <= cfg_ff;
                default:        rdat_ff <= 8'h00;
            endcase
        end
    end

    // configuration store; only power-up reset loads the preset
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_ff <= `SBCW_CFG_PRESET;
        end else if (req_evt && hold_ff.we && hold_ff.addr == `SBCW_A_CFG) begin
            cfg_ff <= hold_ff.wdata & `SBCW_CFG_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            started_ff <= 1'b0;
            uv_ff      <= 2'h0;
        end else if (!started_ff) begin
            started_ff <= 1'b1;
            uv_ff      <= cfg_ff[`SBCW_UV_HI:`SBCW_UV_LO];
        end
    end

    // mode and period selection
    always_ff @(posedge clk) begin
        if (reset) begin
            wmc_ff <= `SBCW_WMC_TMO;
            nwp_ff <= `SBCW_NWP_DEF;
        end else if (sreq) begin
            wmc_ff <= sd ? `SBCW_WMC_AUTO : `SBCW_WMC_TMO;
            nwp_ff <= `SBCW_NWP_DEF;
        end else if (trig) begin
            wmc_ff <= new_wmc;
            nwp_ff <= new_nwp;
        end
    end

    // watchdog timer
    always_ff @(posedge clk) begin
        wdm_ff <= reset ? sbcw_wd_off : nxt_wdm;
        if (reset || sreq || nxt_wdm == sbcw_wd_off || nxt_wdm != wdm_ff) begin
            cnt_ff <= 32'h0;
        end else if (trig || ovf) begin
            cnt_ff <= 32'h0;
        end else if (wake_captured && wmc_ff == `SBCW_WMC_AUTO) begin
            cnt_ff <= 32'h0;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
        end
    end

    // failure flag, set beats clear
    always_ff @(posedge clk) begin
        if (reset) begin
            wdf_ff <= 1'b0;
        end else if (ovf && wdm_ff == sbcw_wd_tmo && !wdf_ff) begin
            wdf_ff <= 1'b1;
        end else if (wdg_fail_clr) begin
            wdf_ff <= 1'b0;
        end
    end

    // receive pin forcing and regulator
    always_ff @(posedge clk) begin
        if (reset) begin
            frx_ff    <= 1'b0;
            reg_on_ff <= 1'b1;
        end else begin
            if ((slp_ovf && wdf_ff) || (wake_captured && wmc_ff == `SBCW_WMC_AUTO)) begin
                frx_ff <= 1'b1;
            end else if (trig || sreq) begin
                frx_ff <= 1'b0;
            end
            if (slp_ovf && wdf_ff) begin
                reg_on_ff <= 1'b1;
            end else if (sleep_go_ff) begin
                reg_on_ff <= 1'b0;
            end else if (op_mode != sbcw_op_sleep) begin
                reg_on_ff <= 1'b1;
            end
        end
    end

    // one-cycle event outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            sleep_go_ff <= 1'b0;
            wake_ev_ff  <= 1'b0;
            stby_go_ff  <= 1'b0;
            spi_fail_ff <= 1'b0;
        end else begin
            sleep_go_ff <= sleep_cmd && !cfg_ff[`SBCW_SLP_BIT];
            wake_ev_ff  <= slp_ovf;
            stby_go_ff  <= wake_captured && wmc_ff == `SBCW_WMC_AUTO &&
                           op_mode == sbcw_op_sleep;
            spi_fail_ff <= wr_ctl && !trig;
        end
    end

    // ==========================================================
    // reset pin: sync, pulse, blanking while the pull-up recovers
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_s1_ff <= 1'b1;
            pin_s2_ff <= 1'b1;
        end else begin
            pin_s1_ff <= reset_pin_n_i;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            drive_ff   <= 1'b0;
            pcnt_ff    <= 32'h0;
            blank_ff   <= `SBCW_BLANK;
            rsc_ff     <= `SBCW_RSC_POR;
            sys_rst_ff <= 1'b0;
        end else begin
            sys_rst_ff <= sreq;
            if (sreq) begin
                drive_ff <= 1'b1;
                pcnt_ff  <= 32'h0;
                rsc_ff   <= nxt_rsc;
                blank_ff <= `SBCW_BLANK;
            end else if (drive_ff) begin
                pcnt_ff <= pcnt_ff + 32'h1;
                if (pcnt_ff >= 32'(RST_PULSE_CYC - 1)) begin
                    drive_ff <= 1'b0;
                end
            end else if (blank_ff != 2'h0) begin
                blank_ff <= blank_ff - 2'h1;
            end
        end
    end

    // outputs
    assign reset_pin_n_o     = 1'b0;
    assign reset_pin_n_oe_n  = ~drive_ff;
    assign sys_reset         = sys_rst_ff;
    assign reset_source_code = rsc_ff;
    assign wdg_fail_flag     = wdf_ff;
    assign force_rxd_low     = frx_ff;
    assign regulator_on      = reg_on_ff;
    assign uv_threshold_sel  = uv_ff;
    assign sleep_go          = sleep_go_ff;
    assign wake_event        = wake_ev_ff;
    assign stby_go           = stby_go_ff;
    assign spi_fail          = spi_fail_ff;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_fn_wdg_off: assert property (fn && $past(fn) |-> wdm_ff == sbcw_wd_off)
        else $error("watchdog active under forced-normal override");
    a_sd_reload: assert property (sreq && sd |=> wmc_ff == `SBCW_WMC_AUTO)
        else $error("sw-dev reset did not load autonomous code");
    a_early_reset: assert property (early && !drive_ff && !wc_bad
        |=> sys_rst_ff && rsc_ff == `SBCW_RSC_EARLY)
        else $error("early trigger did not reset");
    a_late_restart: assert property (trig && wdm_ff == sbcw_wd_win && !early && !sreq
        && nxt_wdm == sbcw_wd_win |=> cnt_ff == 32'h0 ##1 cnt_ff == 32'h1)
        else $error("second-half trigger did not restart timer");
    a_tmo_flag: assert property (ovf && wdm_ff == sbcw_wd_tmo && !wdf_ff |=> wdf_ff)
        else $error("timeout overflow did not flag failure");
    a_tmo_reset: assert property (ovf && wdm_ff == sbcw_wd_tmo && wdf_ff && !drive_ff
        && op_mode != sbcw_op_sleep && !wc_bad |=> sys_rst_ff && rsc_ff == `SBCW_RSC_OVF)
        else $error("second overflow did not reset");
    a_sleep_inh: assert property (sleep_cmd && cfg_ff[`SBCW_SLP_BIT] |=> !sleep_go_ff)
        else $error("sleep command taken while inhibited");
    a_pin_pulse: assert property (sys_rst_ff |-> !reset_pin_n_oe_n ##1 !reset_pin_n_oe_n)
        else $error("reset without pin pulse");
    a_illegal_wmc: assert property (wc_bad && !drive_ff
        |=> sys_rst_ff && rsc_ff == `SBCW_RSC_ILLWM)
        else $error("mode change in normal did not reset");
    a_bad_code: assert property (wr_ctl && !trig && !sreq
        |=> spi_fail_ff && $stable(wmc_ff) && $stable(nwp_ff))
        else $error("invalid code not abandoned");

    c_win_restart: cover property (trig && wdm_ff == sbcw_wd_win && !early);
    c_sleep_wake: cover property (slp_ovf && wdf_ff);
    c_ext_reset: cover property (sreq && nxt_rsc == `SBCW_RSC_EXT);
endmodule

/* File: sbcw_host.sv */
// sbcw_host.sv: host model, link master and reset pin wire.
// assumes: lnk_clk from the bench; one access at a time.
`timescale 1ns/1ps
module sbcw_host
    import sbcw_pkg::*;
(
    input  wire logic       lnk_clk,
    input  wire logic       lnk_done,
    input  wire logic [7:0] lnk_rdata,
    output sbcw_lnk_req_s   lnk_cmd,
    output logic            lnk_req,
    input  wire logic       pin_o,
    input  wire logic       pin_oe_n,
    input  wire logic       host_pull,
    output logic            pin_lvl
);
    // ====================
    // pin has a pull-up; low when either side pulls
    // host pulls low
    assign pin_lvl = !((!pin_oe_n && !pin_o) || host_pull);
    initial begin
        lnk_req = 1'b0;
        lnk_cmd = '0;
    end
    // ====================
    // request dropped once taken, else it would be taken twice
    // write to the control register with valid codes is a trigger
    task automatic access(input logic we, input logic [7:0] a, d, output logic [7:0] rd);
        rd = 'x;
        @(posedge lnk_clk);
        lnk_cmd <= '{we: we, addr: a, wdata: d};
        lnk_req <= 1'b1;
        @(posedge lnk_clk);
        lnk_req <= 1'b0;
        repeat (60) begin
            // done launched at the previous edge is read at this one
            @(posedge lnk_clk);
            if (lnk_done === 1'b1) begin
                rd = lnk_rdata;
                break;
            end
        end
    endtask
endmodule

/* File: sbcw_watchdog_tb_top.sv */
// sbcw_watchdog_tb_top.sv: self-checking bench of the watchdog block.
// assumes: host model compiled first; counts shortened to 10 cycles a ms.
`timescale 1ns/1ps
module sbcw_watchdog_tb_top;
    import sbcw_pkg::*;
    logic         clk = 1'b0;
    logic         lnk_clk = 1'b0;
    logic         reset = 1'b1;
    logic         pull = 1'b0;
    sbcw_opmode_e op_mode = sbcw_op_standby;
    sbcw_lnk_req_s cmd;
    logic         req, done, oe_n, pin_o, pin;
    logic [7:0]   rdata, rd;
    logic [4:0]   src;
    logic         flag;
    logic         sleep_cmd = 1'b0;
    logic         fail_clr = 1'b0;
    logic         sleep_go;
    logic [1:0]   uv;
    int           err_total = 0;
    int           checks = 0;
    // rows: {we, addr, wdata, expected read data}
    localparam logic [24:0] ROWS [11] = '{{1'h0,8'h74,8'h00,8'h08}, {1'h0,8'h05,8'h00,8'h08},
        {1'h0,8'h33,8'h00,8'h00}, {1'h1,8'h74,8'h3F,8'h08}, {1'h0,8'h74,8'h00,8'h3D},
        {1'h1,8'h74,8'h04,8'h3D}, {1'h0,8'h05,8'h00,8'h05}, {1'h1,8'h00,8'h64,8'h44},
        {1'h0,8'h00,8'h00,8'h44}, {1'h1,8'h74,8'h00,8'h04}, {1'h1,8'h00,8'h48,8'h44}};
    always #20 clk = ~clk;
    // link clock offset so the two never line up
    initial begin
        #3.3;
        forever #6 lnk_clk = ~lnk_clk;
    end
    sbcw_watchdog #(.CYC_PER_MS(10), .RST_PULSE_CYC(8)) sbcw_watchdog_inst (
        .clk(clk), .reset(reset), .lnk_clk(lnk_clk), .lnk_reset(reset), .lnk_req(req),
        .lnk_cmd(cmd), .lnk_busy(), .lnk_rdata(rdata), .lnk_done(done), .op_mode(op_mode),
        .rxd_low(1'b0), .wake_captured(1'b0), .sleep_cmd(sleep_cmd), .wdg_fail_clr(fail_clr),
        .sleep_go(sleep_go), .wake_event(), .stby_go(), .spi_fail(), .sys_reset(),
        .reset_source_code(src), .wdg_fail_flag(flag), .force_rxd_low(), .regulator_on(),
        .uv_threshold_sel(uv), .reset_pin_n_i(pin), .reset_pin_n_o(pin_o),
        .reset_pin_n_oe_n(oe_n));
    sbcw_host sbcw_host_inst (.lnk_clk(lnk_clk), .lnk_done(done), .lnk_rdata(rdata),
        .lnk_cmd(cmd), .lnk_req(req), .pin_o(pin_o), .pin_oe_n(oe_n), .host_pull(pull),
        .pin_lvl(pin));
    task automatic chk(input logic [7:0] g, e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rw(input logic we, input logic [7:0] a, d, e);
        sbcw_host_inst.access(we, a, d, rd);
        chk(rd, e);
    endtask
    task automatic wclk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one sleep command pulse, accepted flag read while it stands
    task automatic slp(input logic e);
        wclk(1);
        sleep_cmd <= 1'b1;
        wclk(1);
        sleep_cmd <= 1'b0;
        wclk(1);
        chk({7'h00, sleep_go}, {7'h00, e});
    endtask
    task automatic finish_test;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog: whole run needs about 500 clocks
    initial begin
        #200000;
        err_total++;
        finish_test;
    end
    initial begin
        wclk(16);
        reset <= 1'b0;
        wclk(4);
        for (int i = 0; i < 11; i++) begin
            rw(ROWS[i][24], ROWS[i][23:16], ROWS[i][15:8], ROWS[i][7:0]);
        end
        wclk(85);
        chk({7'h00, flag}, 8'h01);
        wclk(85);
        chk({3'h0, src}, 8'h0F);
        wclk(20);
        rw(1'b1, 8'h00, 8'h84, 8'h44);
        wclk(1);
        op_mode <= sbcw_op_normal;
        wclk(3);
        rw(1'b1, 8'h00, 8'h84, 8'h84);
        chk({3'h0, src}, 8'h0E);
        repeat (20) begin
            if (oe_n === 1'b0) break;
            @(posedge clk);
        end
        chk({7'h00, oe_n}, 8'h00);
        wclk(20);
        rw(1'b1, 8'h00, 8'h24, 8'h44);
        wclk(2);
        chk({3'h0, src}, 8'h10);
        wclk(20);
        pull <= 1'b1;
        wclk(6);
        pull <= 1'b0;
        wclk(4);
        chk({3'h0, src}, 8'h11);
        rw(1'b0, 8'h74, 8'h00, 8'h00);
        // window mode with the 8 ms period: late trigger, then overflow
        wclk(1);
        op_mode <= sbcw_op_standby;
        rw(1'b1, 8'h00, 8'h88, 8'h44);
        wclk(1);
        op_mode <= sbcw_op_normal;
        wclk(45);
        rw(1'b1, 8'h00, 8'h88, 8'h88);
        rw(1'b0, 8'h05, 8'h00, 8'h01);
        chk({3'h0, src}, 8'h11);
        wclk(90);
        chk({3'h0, src}, 8'h0F);
        // host clears the pending failure
        wclk(1);
        fail_clr <= 1'b1;
        wclk(1);
        fail_clr <= 1'b0;
        wclk(1);
        chk({7'h00, flag}, 8'h00);
        // power-up reset in mid-run restores presets
        reset <= 1'b1;
        wclk(3);
        reset <= 1'b0;
        wclk(4);
        chk({3'h0, src}, 8'h00);
        chk({6'h00, uv}, 8'h00);
        slp(1'b1);
        rw(1'b1, 8'h74, 8'h09, 8'h08);
        slp(1'b0);
        finish_test;
    end
endmodule
